// *** diskette_host_port.sv ***
// Overview of operation
// R1: drive control bits 1:0 pick one of four drives, only if motor on
// R2: drive control register is 8-bit write-only, cleared by interface reset
// R3: controller held in reset while drive control bit 2 is zero
// R4: bit 3 gates controller interrupt and DMA requests onto the bus
// R5: bits 4 to 7 switch motors 0 to 3; motor off blocks selection
// R6: command unit-select field uses the same drive encoding as bits 1:0
// R7: address line 0 low reads main status, high reaches data stack
// R8: main status is 8-bit read-only, readable any time without side effects
// R9: status bits 0 to 3 set while matching drive is seeking
// R10: status bit 4 set while a read or write command is in progress
// R11: status bit 5 set while executing in non-DMA mode
// R12: status bit 6 gives direction, one means controller to host
// R13: status bit 7 set when the data register can exchange a byte
// R14: host checks ready and direction bits before each data access
// R15: data register is a stack presenting one byte at a time
// R16: fifteen commands, each a multi-byte write, some with multi-byte results; sense interrupt is a single-byte write here
// R17: each command has command, execution and result phases; here specify has command phase only, seek/recal no result, sense commands no execution
// R18: four result status bytes readable only in the result phase
// R19: head load delay programmable 4 to 512 ms in 4 ms steps
// R20: head unload delay programmable 0 to 480 ms in 32 ms steps
// R21: step interval programmable 2 to 32 ms in 2 ms steps
// R22: scan step 1 compares contiguous sectors, 2 alternate sectors
// R23: host writes only when ready with direction 0, reads with direction 1
`timescale 1ns/1ps
module diskette_host_port
    import diskette_port_pkg::*;
#(
    parameter int unsigned CYCLES_PER_MS = MS_CYCLES
) (
    input wire logic CORE_CLK,
    input wire logic RESETN,
    input wire logic CTL_WR_STB,
    input wire logic PORT_WR_STB,
    input wire logic PORT_RD_STB,
    input wire logic REGISTER_SELECT_LINE,
    input wire logic [7:0] IO_WDATA,
    input wire logic DMA_ACK,
    output logic [7:0] IO_RDATA,
    output logic [3:0] MOTOR_ON,
    output logic [3:0] DRIVE_SEL,
    output logic CTRL_RESET,
    output logic INT_REQ,
    output logic DMA_REQ,
    output logic HEAD_LOAD,
    output logic STEP_PULSE
);
    function automatic logic [3:0] unit_onehot(input logic [1:0] u);
        return 4'h1 << u;
    endfunction : unit_onehot

    function automatic logic [3:0] cmd_len(input logic [4:0] op);
        case (op)
            OP_READ, OP_READ_DEL, OP_WRITE, OP_WRITE_DEL,
            OP_READ_TRACK, OP_SCAN_EQ, OP_SCAN_LE, OP_SCAN_HE: return 4'h9;
            OP_FORMAT: return 4'h6;
            OP_SPECIFY, OP_SEEK: return 4'h3;
            OP_READ_ID, OP_RECAL, OP_SENSE_DRIVE: return 4'h2;
            default: return 4'h1;
        endcase
    endfunction : cmd_len

    function automatic logic is_data(input logic [4:0] op);
        return cmd_len(op) == 4'h9 || op == OP_FORMAT || op == OP_READ_ID;
    endfunction : is_data

    function automatic logic is_write(input logic [4:0] op);
        return op == OP_WRITE || op == OP_WRITE_DEL || op == OP_FORMAT;
    endfunction : is_write

    function automatic logic is_scan(input logic [4:0] op);
        return op == OP_SCAN_EQ || op == OP_SCAN_LE || op == OP_SCAN_HE;
    endfunction : is_scan

    logic [7:0] dor_q;
    logic ctl_rst;
    ctl_state_t state_q;
    logic [3:0] idx_q;
    logic [3:0] len_q;
    logic [3:0] res_len_q;
    logic [4:0] op_q;
    logic [1:0] unit_q;
    logic hd_q;
    logic nd_q;
    logic [3:0] srt_q;
    logic [3:0] hut_q;
    logic [6:0] hlt_q;
    logic [7:0] stp_q;
    logic [7:0] tgt_q;
    logic [7:0] pcn_q [4];
    logic [7:0] st0_int_q;
    logic [1:0] int_unit_q;
    logic int_pend_q;
    logic int_q;
    logic dma_q;
    logic step_q;
    logic head_q;
    logic exec_start_q;
    logic [MS_W-1:0] exec_ms_q;
    logic unload_start_q;
    logic exec_done;
    logic unload_done;
    logic [7:0] stack_rd;
    logic wr_data;
    logic rd_data;
    logic [3:0] cur_len;
    logic [4:0] cur_op;
    logic last_byte;
    logic [7:0] msr;
    logic [7:0] res_byte;
    logic [7:0] st3;

    // interface reset clears all control bits
    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            dor_q <= DOR_RESET; // see R2
        end else if (CTL_WR_STB) begin
            dor_q <= IO_WDATA;
        end
    end

    assign ctl_rst = !RESETN || !dor_q[DOR_RUN_BIT]; // see R3

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            MOTOR_ON <= 4'h0;
            DRIVE_SEL <= 4'h0;
            CTRL_RESET <= 1'b1;
        end else begin
            MOTOR_ON <= dor_q[DOR_MOTOR_LSB +: 4]; // see R5
            DRIVE_SEL <= unit_onehot(dor_q[DOR_SEL_LSB +: 2])
                & dor_q[DOR_MOTOR_LSB +: 4]; // see R1
            CTRL_RESET <= ctl_rst; // see R3
        end
    end

    assign wr_data = PORT_WR_STB && REGISTER_SELECT_LINE == SEL_DATA; // see R7
    assign rd_data = PORT_RD_STB && REGISTER_SELECT_LINE == SEL_DATA; // see R7
    assign cur_op = (idx_q == 4'h0) ? IO_WDATA[4:0] : op_q;
    assign cur_len = (idx_q == 4'h0) ? cmd_len(IO_WDATA[4:0]) : len_q;
    assign last_byte = idx_q == cur_len - 4'h1;

    // status is pure decode of state, so reading it disturbs nothing
    always_comb begin
        msr = 8'h00;
        msr[3:0] = (state_q == S_SEEK) ? unit_onehot(unit_q) : 4'h0; // see R9
        msr[MSR_BUSY_BIT] = is_data(op_q) && state_q != S_CMD
            && state_q != S_SEEK; // see R10
        msr[MSR_NDM_BIT] = state_q == S_XFER && nd_q; // see R11
        msr[MSR_DIO_BIT] = state_q == S_RESULT
            || (state_q == S_XFER && !is_write(op_q)); // see R12
        msr[MSR_RQM_BIT] = state_q == S_CMD || state_q == S_RESULT
            || (state_q == S_XFER && nd_q); // see R13
    end

    assign st3 = {2'b00, 1'b1, pcn_q[unit_q] == 8'h00, 1'b0, hd_q, unit_q};

    // result bytes are reachable only through the result phase
    always_comb begin
        res_byte = ST0_INVALID;
        if (is_data(op_q)) begin
            case (idx_q)
                4'h0: res_byte = {5'h00, hd_q, unit_q}; // see R18
                4'h1, 4'h2: res_byte = 8'h00;
                4'h5: res_byte = stack_rd
                    + (is_scan(op_q) ? stp_q : 8'h01); // see R22
                default: res_byte = stack_rd;
            endcase
        end else if (op_q == OP_SENSE_INT && int_pend_q) begin
            res_byte = (idx_q == 4'h0) ? st0_int_q : pcn_q[int_unit_q];
        end else if (op_q == OP_SENSE_DRIVE) begin
            res_byte = st3;
        end
    end

    param_stack #(
        .DEPTH(STACK_DEPTH),
        .W(8)
    ) u_stack (
        .clk(CORE_CLK),
        .we(wr_data && state_q == S_CMD), // see R15
        .waddr(idx_q),
        .wdata(IO_WDATA),
        .raddr(idx_q - 4'h1),
        .rdata(stack_rd)
    );

    ms_delay_timer #(
        .TICK_CYCLES(CYCLES_PER_MS),
        .MW(MS_W)
    ) u_exec_tmr (
        .clk(CORE_CLK),
        .rst_n(!ctl_rst),
        .start(exec_start_q),
        .ms(exec_ms_q),
        .done(exec_done)
    );

    ms_delay_timer #(
        .TICK_CYCLES(CYCLES_PER_MS),
        .MW(MS_W)
    ) u_unload_tmr (
        .clk(CORE_CLK),
        .rst_n(!ctl_rst),
        .start(unload_start_q),
        .ms(MS_W'(hut_q * HUT_STEP_MS)), // see R20
        .done(unload_done)
    );

    // parameter fields picked off as the command bytes arrive
    always_ff @(posedge CORE_CLK) begin
        if (ctl_rst) begin
            unit_q <= 2'b00;
            hd_q <= 1'b0;
            srt_q <= 4'h0;
            hut_q <= 4'h0;
            hlt_q <= 7'h00;
            nd_q <= 1'b0;
            stp_q <= 8'h01;
            tgt_q <= 8'h00;
        end else if (wr_data && state_q == S_CMD) begin
            if (idx_q == 4'h1 && op_q == OP_SPECIFY) begin
                srt_q <= IO_WDATA[7:4]; // see R21
                hut_q <= IO_WDATA[3:0]; // see R20
            end else if (idx_q == 4'h1) begin
                unit_q <= IO_WDATA[1:0]; // see R6
                hd_q <= IO_WDATA[2];
            end
            if (idx_q == 4'h2 && op_q == OP_SPECIFY) begin
                hlt_q <= IO_WDATA[7:1]; // see R19
                nd_q <= IO_WDATA[0];
            end
            if (idx_q == 4'h2 && op_q == OP_SEEK) begin
                tgt_q <= IO_WDATA;
            end
            if (idx_q == 4'h1 && cur_op == OP_RECAL) begin
                tgt_q <= 8'h00;
            end
            if (idx_q == 4'h8) begin
                stp_q <= IO_WDATA; // see R22
            end
        end
    end

    // command, execution and result phases
    always_ff @(posedge CORE_CLK) begin
        if (ctl_rst) begin
            state_q <= S_CMD;
            idx_q <= 4'h0;
            len_q <= 4'h1;
            res_len_q <= 4'h1;
            op_q <= 5'h00;
            exec_start_q <= 1'b0;
            exec_ms_q <= '0;
            unload_start_q <= 1'b0;
            step_q <= 1'b0;
            dma_q <= 1'b0;
            for (int i = 0; i < 4; i++) begin
                pcn_q[i] <= 8'h00;
            end
        end else begin
            exec_start_q <= 1'b0;
            unload_start_q <= 1'b0;
            step_q <= 1'b0;
            case (state_q)
                S_CMD: begin
                    if (wr_data) begin // see R16
                        if (idx_q == 4'h0) begin
                            op_q <= IO_WDATA[4:0];
                            len_q <= cmd_len(IO_WDATA[4:0]);
                        end
                        idx_q <= last_byte ? 4'h0 : idx_q + 4'h1;
                        if (last_byte) begin // see R17
                            if (is_data(cur_op)) begin
                                state_q <= S_HLOAD;
                                res_len_q <= 4'h7;
                                exec_start_q <= 1'b1;
                                exec_ms_q <= MS_W'(((hlt_q == 7'h00)
                                    ? HLT_FULL_UNITS : int'(hlt_q))
                                    * HLT_STEP_MS); // see R19
                            end else if (cur_op == OP_SEEK
                                    || cur_op == OP_RECAL) begin
                                state_q <= S_SEEK;
                                exec_start_q <= 1'b1;
                                exec_ms_q <= MS_W'((SRT_SPAN - int'(srt_q))
                                    * SRT_STEP_MS); // see R21
                            end else if (cur_op == OP_SPECIFY) begin
                                state_q <= S_CMD;
                            end else begin
                                state_q <= S_RESULT;
                                res_len_q <= (cur_op == OP_SENSE_INT
                                    && int_pend_q) ? 4'h2 : 4'h1;
                            end
                        end
                    end
                end
                S_HLOAD: begin
                    if (exec_done) begin
                        state_q <= S_XFER;
                        dma_q <= !nd_q;
                    end
                end
                S_XFER: begin
                    if ((nd_q && (is_write(op_q) ? wr_data : rd_data))
                            || (!nd_q && DMA_ACK)) begin
                        state_q <= S_RESULT;
                        dma_q <= 1'b0;
                        unload_start_q <= 1'b1;
                    end
                end
                S_SEEK: begin
                    if (pcn_q[unit_q] == tgt_q) begin
                        state_q <= S_CMD;
                    end else if (exec_done) begin
                        pcn_q[unit_q] <= (pcn_q[unit_q] < tgt_q)
                            ? pcn_q[unit_q] + 8'h01
                            : pcn_q[unit_q] - 8'h01;
                        step_q <= 1'b1;
                        exec_start_q <= 1'b1; // see R21
                    end
                end
                S_RESULT: begin
                    if (rd_data) begin // see R18
                        idx_q <= (idx_q == res_len_q - 4'h1)
                            ? 4'h0 : idx_q + 4'h1;
                        if (idx_q == res_len_q - 4'h1) begin
                            state_q <= S_CMD;
                        end
                    end
                end
                default: state_q <= S_CMD;
            endcase
        end
    end

    // seek completion is held for the sense interrupt command
    always_ff @(posedge CORE_CLK) begin
        if (ctl_rst) begin
            int_pend_q <= 1'b0;
            st0_int_q <= 8'h00;
            int_unit_q <= 2'b00;
        end else if (state_q == S_SEEK && pcn_q[unit_q] == tgt_q) begin
            int_pend_q <= 1'b1;
            st0_int_q <= ST0_SEEK_END | {6'h00, unit_q};
            int_unit_q <= unit_q;
        end else if (state_q == S_RESULT && op_q == OP_SENSE_INT
                && rd_data && idx_q == res_len_q - 4'h1) begin
            int_pend_q <= 1'b0;
        end
    end

    // a new completion in the clearing cycle keeps the request up
    always_ff @(posedge CORE_CLK) begin
        if (ctl_rst) begin
            int_q <= 1'b0;
        end else if ((state_q == S_XFER && unload_start_q == 1'b0
                && ((nd_q && (is_write(op_q) ? wr_data : rd_data))
                || (!nd_q && DMA_ACK)))
                || (state_q == S_SEEK && pcn_q[unit_q] == tgt_q)) begin
            int_q <= 1'b1;
        end else if (state_q == S_RESULT && rd_data) begin
            int_q <= 1'b0;
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (ctl_rst) begin
            head_q <= 1'b0;
        end else if (state_q == S_HLOAD) begin
            head_q <= 1'b1;
        end else if (unload_done) begin
            head_q <= 1'b0; // see R20
        end
    end

    always_ff @(posedge CORE_CLK) begin
        if (!RESETN) begin
            INT_REQ <= 1'b0;
            DMA_REQ <= 1'b0;
            HEAD_LOAD <= 1'b0;
            STEP_PULSE <= 1'b0;
            IO_RDATA <= 8'h00;
        end else begin
            INT_REQ <= int_q && dor_q[DOR_GATE_BIT]; // see R4
            DMA_REQ <= dma_q && dor_q[DOR_GATE_BIT]; // see R4
            HEAD_LOAD <= head_q;
            STEP_PULSE <= step_q;
            if (PORT_RD_STB) begin
                IO_RDATA <= (REGISTER_SELECT_LINE == SEL_STATUS) ? msr
                    : (state_q == S_RESULT ? res_byte : 8'h00); // see R8
            end
        end
    end

    default clocking cb @(posedge CORE_CLK); endclocking
    default disable iff (!RESETN);

    property p_sel_motor;
        (DRIVE_SEL & ~MOTOR_ON) == 4'h0 && $onehot0(DRIVE_SEL);
    endproperty
    a_sel_motor: assert property (p_sel_motor) // see R1
        else $error("drive selected without its motor");

    property p_dor_clear;
        $rose(RESETN) |-> dor_q == DOR_RESET && MOTOR_ON == 4'h0;
    endproperty
    a_dor_clear: assert property (disable iff (1'b0) p_dor_clear) // see R2
        else $error("control register not cleared by reset");

    property p_held;
        !dor_q[DOR_RUN_BIT] |=> state_q == S_CMD && CTRL_RESET && !int_q;
    endproperty
    a_held: assert property (p_held) // see R3
        else $error("controller not held while run bit clear");

    property p_gate;
        !dor_q[DOR_GATE_BIT] |=> !INT_REQ && !DMA_REQ;
    endproperty
    a_gate: assert property (p_gate) // see R4
        else $error("requests escaped with gate clear");

    property p_status_read;
        PORT_RD_STB && REGISTER_SELECT_LINE == SEL_STATUS && !ctl_rst
            |=> IO_RDATA == $past(msr) && idx_q == $past(idx_q);
    endproperty
    a_status_read: assert property (p_status_read) // see R8
        else $error("status read wrong or disturbed state");

    property p_seek_bits;
        msr[3:0] != 4'h0 |-> state_q == S_SEEK && msr[3:0] == unit_onehot(unit_q);
    endproperty
    a_seek_bits: assert property (p_seek_bits) // see R9
        else $error("seek bits without seek");

    property p_busy;
        state_q == S_XFER |-> msr[MSR_BUSY_BIT];
    endproperty
    a_busy: assert property (p_busy) // see R10
        else $error("busy bit low during transfer");

    property p_result_dir;
        state_q == S_RESULT |-> msr[MSR_DIO_BIT] && msr[MSR_RQM_BIT]
            && !msr[MSR_NDM_BIT];
    endproperty
    a_result_dir: assert property (p_result_dir) // see R12
        else $error("result phase handshake bits wrong");

    sequence s_last_spec;
        state_q == S_CMD && wr_data && last_byte && cur_op == OP_SPECIFY;
    endsequence
    property p_specify_no_result;
        s_last_spec |=> state_q == S_CMD && idx_q == 4'h0;
    endproperty
    a_specify_no_result: assert property (p_specify_no_result) // see R17
        else $error("specify entered a result phase");

    sequence s_hload_end;
        state_q == S_HLOAD && exec_done && !ctl_rst;
    endsequence
    property p_hload;
        s_hload_end |=> state_q == S_XFER && HEAD_LOAD;
    endproperty
    a_hload: assert property (p_hload) // see R19
        else $error("head load delay did not lead to transfer");
endmodule : diskette_host_port

// *** diskette_port_pkg.sv ***
package diskette_port_pkg;
    // bus decode
    localparam logic [11:0] MAIN_STATUS_OFFSET = 12'h34F;
    localparam logic SEL_STATUS = 1'b0;
    localparam logic SEL_DATA = 1'b1;
    // drive control register fields
    localparam logic [7:0] DOR_RESET = 8'h00;
    localparam int DOR_SEL_LSB = 0;
    localparam int DOR_RUN_BIT = 2;
    localparam int DOR_GATE_BIT = 3;
    localparam int DOR_MOTOR_LSB = 4;
    // main status fields
    localparam int MSR_BUSY_BIT = 4;
    localparam int MSR_NDM_BIT = 5;
    localparam int MSR_DIO_BIT = 6;
    localparam int MSR_RQM_BIT = 7;
    // timing
    localparam int CLK_PERIOD_NS = 8;
    localparam int MS_NS = 1000000;
    localparam int MS_CYCLES = MS_NS / CLK_PERIOD_NS;
    localparam int HLT_STEP_MS = 4;
    localparam int HLT_FULL_UNITS = 128;
    localparam int HUT_STEP_MS = 32;
    localparam int SRT_STEP_MS = 2;
    localparam int SRT_SPAN = 16;
    localparam int MS_W = 10;
    // command set
    localparam int NUM_COMMANDS = 15;
    localparam int STACK_DEPTH = 9;
    localparam logic [4:0] OP_READ_TRACK = 5'h02;
    localparam logic [4:0] OP_SPECIFY = 5'h03;
    localparam logic [4:0] OP_SENSE_DRIVE = 5'h04;
    localparam logic [4:0] OP_WRITE = 5'h05;
    localparam logic [4:0] OP_READ = 5'h06;
    localparam logic [4:0] OP_RECAL = 5'h07;
    localparam logic [4:0] OP_SENSE_INT = 5'h08;
    localparam logic [4:0] OP_WRITE_DEL = 5'h09;
    localparam logic [4:0] OP_READ_ID = 5'h0A;
    localparam logic [4:0] OP_READ_DEL = 5'h0C;
    localparam logic [4:0] OP_FORMAT = 5'h0D;
    localparam logic [4:0] OP_SEEK = 5'h0F;
    localparam logic [4:0] OP_SCAN_EQ = 5'h11;
    localparam logic [4:0] OP_SCAN_LE = 5'h19;
    localparam logic [4:0] OP_SCAN_HE = 5'h1D;
    localparam logic [7:0] ST0_INVALID = 8'h80;
    localparam logic [7:0] ST0_SEEK_END = 8'h20;
    typedef enum {S_CMD, S_HLOAD, S_XFER, S_SEEK, S_RESULT} ctl_state_t;
endpackage : diskette_port_pkg

// *** ms_delay_timer.sv ***
`timescale 1ns/1ps
module ms_delay_timer #(
    parameter int unsigned TICK_CYCLES = 125000,
    parameter int MW = 10
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic start,
    input wire logic [MW-1:0] ms,
    output logic done
);
    localparam int PW = $clog2(TICK_CYCLES);
    logic [PW-1:0] pre_q;
    logic [MW-1:0] left_q;
    logic run_q;

    // a fresh start drops any delay still running
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            pre_q <= '0;
            left_q <= '0;
            run_q <= 1'b0;
            done <= 1'b0;
        end else if (start) begin
            pre_q <= '0;
            left_q <= ms;
            run_q <= 1'b1;
            done <= 1'b0;
        end else if (run_q && left_q == '0) begin
            run_q <= 1'b0;
            done <= 1'b1;
        end else if (run_q) begin
            done <= 1'b0;
            if (pre_q == PW'(TICK_CYCLES - 1)) begin
                pre_q <= '0;
                left_q <= left_q - 1'b1;
            end else begin
                pre_q <= pre_q + 1'b1;
            end
        end else begin
            done <= 1'b0;
        end
    end
endmodule : ms_delay_timer

// *** param_stack.sv ***
`timescale 1ns/1ps
module param_stack #(
    parameter int DEPTH = 9,
    parameter int W = 8
) (
    input wire logic clk,
    input wire logic we,
    input wire logic [3:0] waddr,
    input wire logic [W-1:0] wdata,
    input wire logic [3:0] raddr,
    output logic [W-1:0] rdata
);
    logic [W-1:0] mem [DEPTH];

    // no reset: contents only matter once a command has filled them
    always_ff @(posedge clk) begin
        if (we && int'(waddr) < DEPTH) begin
            mem[waddr] <= wdata;
        end
    end

    always_ff @(posedge clk) begin
        rdata <= (int'(raddr) < DEPTH) ? mem[raddr] : '0;
    end
endmodule : param_stack

// *** host_bus_model.sv ***
`timescale 1ns/1ps
module host_bus_model
    import diskette_port_pkg::*;
(
    input wire logic CORE_CLK,
    input wire logic [7:0] IO_RDATA,
    output logic CTL_WR_STB,
    output logic PORT_WR_STB,
    output logic PORT_RD_STB,
    output logic REGISTER_SELECT_LINE,
    output logic [7:0] IO_WDATA,
    output logic DMA_ACK
);
    initial begin
        {CTL_WR_STB, PORT_WR_STB, PORT_RD_STB, DMA_ACK} = 4'h0;
        REGISTER_SELECT_LINE = SEL_STATUS;
        IO_WDATA = 8'h00;
    end
    // data is inverted after release so no stale byte looks valid
    task automatic cyc(input logic [2:0] k, input logic a0,
                       input logic [7:0] d, output logic [7:0] q);
        @(negedge CORE_CLK);
        {CTL_WR_STB, PORT_WR_STB, PORT_RD_STB} = k;
        REGISTER_SELECT_LINE = a0;
        IO_WDATA = d;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        q = IO_RDATA;
        {CTL_WR_STB, PORT_WR_STB, PORT_RD_STB} = 3'h0;
        IO_WDATA = ~d;
    endtask : cyc
    task automatic ready(input logic dir);
        logic [7:0] s;
        for (int i = 0; i < 3000; i++) begin
            cyc(3'h1, SEL_STATUS, 8'h00, s);
            if (s[MSR_RQM_BIT] === 1'b1 && s[MSR_DIO_BIT] === dir) break;
        end
    endtask : ready
    task automatic ctl(input logic [7:0] d);
        logic [7:0] q;
        cyc(3'h4, SEL_STATUS, d, q);
    endtask : ctl
    task automatic put(input logic [7:0] d);
        logic [7:0] q;
        ready(1'b0);
        cyc(3'h2, SEL_DATA, d, q);
    endtask : put
    task automatic get(output logic [7:0] q);
        ready(1'b1);
        cyc(3'h1, SEL_DATA, 8'h00, q);
    endtask : get
    task automatic ack();
        @(negedge CORE_CLK);
        DMA_ACK = 1'b1;
        @(posedge CORE_CLK);
        @(negedge CORE_CLK);
        DMA_ACK = 1'b0;
    endtask : ack
endmodule : host_bus_model

// *** diskette_adapter_host_port_test.sv ***
`timescale 1ns/1ps
module diskette_adapter_host_port_test
    import diskette_port_pkg::*;
;
    localparam int CPM = 4;
    // timer done and restart registers add three cycles to every step
    localparam int STEP_LAG = 3;
    typedef struct {logic [7:0] d; logic [3:0] m; logic [3:0] s; logic r;} row_t;
    row_t rows [6] = '{'{8'h1C, 4'h1, 4'h1, 1'b0}, '{8'h25, 4'h2, 4'h2, 1'b0},
        '{8'h42, 4'h4, 4'h4, 1'b1}, '{8'h87, 4'h8, 4'h8, 1'b0},
        '{8'h13, 4'h1, 4'h0, 1'b1}, '{8'hF6, 4'hF, 4'h4, 1'b0}};
    logic [7:0] rd_cmd [9] = '{8'h06, 8'h05, 8'h03, 8'h01, 8'h02, 8'h02,
        8'h09, 8'h1B, 8'hFF};
    logic [7:0] res [7] = '{8'h05, 8'h00, 8'h00, 8'h03, 8'h01, 8'h03, 8'h02};
    logic CORE_CLK, RESETN;
    logic [7:0] q;
    wire CTL_WR_STB, PORT_WR_STB, PORT_RD_STB, DMA_ACK;
    wire REGISTER_SELECT_LINE, CTRL_RESET, INT_REQ, DMA_REQ;
    wire HEAD_LOAD, STEP_PULSE;
    wire [7:0] IO_WDATA, IO_RDATA;
    wire [3:0] MOTOR_ON, DRIVE_SEL;
    int err_count = 0;
    int samples_checked = 0;
    int cyc_n = 0, step_n = 0, step_at = 0, step_gap = 0, n;
    diskette_host_port #(.CYCLES_PER_MS(CPM)) uut (.CORE_CLK(CORE_CLK),
        .RESETN(RESETN), .CTL_WR_STB(CTL_WR_STB), .PORT_WR_STB(PORT_WR_STB),
        .PORT_RD_STB(PORT_RD_STB), .REGISTER_SELECT_LINE(REGISTER_SELECT_LINE),
        .IO_WDATA(IO_WDATA), .DMA_ACK(DMA_ACK), .IO_RDATA(IO_RDATA),
        .MOTOR_ON(MOTOR_ON), .DRIVE_SEL(DRIVE_SEL), .CTRL_RESET(CTRL_RESET),
        .INT_REQ(INT_REQ), .DMA_REQ(DMA_REQ), .HEAD_LOAD(HEAD_LOAD),
        .STEP_PULSE(STEP_PULSE));
    host_bus_model host (.CORE_CLK(CORE_CLK), .IO_RDATA(IO_RDATA),
        .CTL_WR_STB(CTL_WR_STB), .PORT_WR_STB(PORT_WR_STB),
        .PORT_RD_STB(PORT_RD_STB), .REGISTER_SELECT_LINE(REGISTER_SELECT_LINE),
        .IO_WDATA(IO_WDATA), .DMA_ACK(DMA_ACK));
    initial begin
        CORE_CLK = 1'b0;
        forever #4 CORE_CLK = ~CORE_CLK;
    end
    // step spacing is measured from the pulses themselves
    always @(posedge CORE_CLK) begin
        cyc_n <= cyc_n + 1;
        if (STEP_PULSE === 1'b1) begin
            step_n <= step_n + 1;
            step_gap <= cyc_n - step_at;
            step_at <= cyc_n;
        end
    end
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            err_count++;
            $display("MISMATCH t=%0t seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        $display("checks %0d mismatches %0d", samples_checked, err_count);
        if (err_count == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : conclude
    initial begin
        #(8 * 20000);
        err_count++;
        conclude();
    end
    initial begin
        RESETN = 1'b0;
        repeat (20) @(negedge CORE_CLK);
        RESETN = 1'b1;
        chk({MOTOR_ON, DRIVE_SEL}, 8'h00);
        chk(CTRL_RESET, 1'b1);
        foreach (rows[i]) begin
            host.ctl(rows[i].d);
            repeat (2) @(negedge CORE_CLK);
            chk(MOTOR_ON, rows[i].m);
            chk(DRIVE_SEL, rows[i].s);
            chk(CTRL_RESET, rows[i].r);
        end
        host.ctl(8'h1C);
        host.cyc(3'h1, SEL_DATA, 8'h00, q);
        chk(q, 8'h00);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q, 8'h80);
        host.put(8'h1F);
        host.get(q);
        chk(q, ST0_INVALID);
        host.put({3'h0, OP_SPECIFY});
        host.put(8'hE1);
        host.put(8'h02);
        host.put({3'h0, OP_SEEK});
        host.put(8'h01);
        host.put(8'h03);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q[1], 1'b1);
        for (n = 0; n < 400 && INT_REQ !== 1'b1; n++) @(negedge CORE_CLK);
        chk(8'(step_n), 8'h03);
        chk(8'(step_gap), 8'(4 * CPM + STEP_LAG));
        host.put({3'h0, OP_SENSE_INT});
        host.get(q);
        chk(q, 8'h21);
        host.get(q);
        chk(q, 8'h03);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q, 8'h80);
        foreach (rd_cmd[i]) host.put(rd_cmd[i]);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q, 8'h10);
        for (n = 0; n < 100 && DMA_REQ !== 1'b1; n++) @(negedge CORE_CLK);
        chk(n >= 8 && n <= 20, 1'b1);
        host.ctl(8'h14);
        repeat (2) @(negedge CORE_CLK);
        chk(DMA_REQ, 1'b0);
        host.ctl(8'h1C);
        repeat (2) @(negedge CORE_CLK);
        chk(DMA_REQ, 1'b1);
        host.ack();
        for (n = 0; n < 20 && INT_REQ !== 1'b1; n++) @(negedge CORE_CLK);
        chk(INT_REQ, 1'b1);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q, 8'hD0);
        foreach (res[i]) begin
            host.get(q);
            chk(q, res[i]);
        end
        chk(INT_REQ, 1'b0);
        chk(HEAD_LOAD, 1'b1);
        repeat (150) @(negedge CORE_CLK);
        chk(HEAD_LOAD, 1'b0);
        host.put({3'h0, OP_SPECIFY});
        host.put(8'hE1);
        host.put(8'h03);
        foreach (rd_cmd[i]) host.put(i ? rd_cmd[i] : {3'h0, OP_WRITE});
        host.ready(1'b0);
        host.cyc(3'h1, SEL_STATUS, 8'h00, q);
        chk(q, 8'hB0);
        host.put(8'hA5);
        foreach (res[i]) begin
            host.get(q);
            chk(q, res[i]);
        end
        RESETN = 1'b0;
        repeat (2) @(negedge CORE_CLK);
        RESETN = 1'b1;
        chk({MOTOR_ON, DRIVE_SEL}, 8'h00);
        chk(CTRL_RESET, 1'b1);
        conclude();
    end
endmodule : diskette_adapter_host_port_test
